// ==== rtl/gpio_port_b.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_defs.svh"

// Contract
// RQ1: Eight independent bidirectional pins, each with direction, latch and readable level.
// RQ2: Direction one makes pin input, zero drives the latch bit.
// RQ3: Output latch is separately accessible and reads back latched values.
// RQ4: Clearing control bit seven of control byte two enables all pull-ups.
// RQ5: A pin driven as output never has its pull-up on.
// RQ6: Pull-ups are off after power-on reset.
// RQ7: After reset pins four to zero are analog and read zero; upper digital.
// RQ8: Configuration byte bit one picks analog or digital default for low pins.
// RQ9: Only pins seven to four are compared, and outputs are excluded.
// RQ10: Each port read snapshots pins seven to four; comparison runs continuously.
// RQ11: Mismatches are ORed to set the change flag.
// RQ12: Port read or write ends mismatch, except memory-to-memory move writes.
// RQ13: Mismatch keeps setting the flag; software reads port then clears flag.
// RQ14: A change condition raises a wake request.
// RQ15: Software should not poll the port while change detection is used.
// RQ16: External USB transceiver mode drives pins two and three as outputs.
// RQ17: Pin four can carry the parallel port chip select.
// RQ18: Active serial data output has priority over the latch.
// RQ19: Analog selection disables the digital input but not the output driver.
// RQ20: Alternate functions that own a pin ignore its direction bit.
// RQ21: Port write updates latch; read returns levels, analog pins as zero.
module gpio_port_b
	import gpio_port_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] config_byte_three_high,
	input wire reg_req_t req,
	input wire alt_func_t alt,
	output logic [7:0] pin_out_q,
	output logic [7:0] pin_oe_q,
	output logic [7:0] pullup_en_q,
	output logic [7:0] pin_level_reg_q,
	output logic [7:0] output_latch_reg_q,
	output logic [7:0] pin_direction_reg_q,
	output logic [4:0] analog_select_reg_q,
	output logic pullup_enable_n_q,
	output logic pin_change_flag_q,
	output logic wake_req_q
);

	logic [7:0] pin_sync_q;
	logic strap_done_q;
	logic [3:0] snap_q;
	logic [7:0] level;
	logic [7:0] eff_oe;
	logic [7:0] eff_out;
	logic mismatch;
	logic touch_port;

	// ==========================================================
	// Pin input synchroniser.
	pin_sync #(
		.W(`PORT_WIDTH)
	) u_pin_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(pin_in),
		.sync_q(pin_sync_q)
	);

	// ==========================================================
	// Direction register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_direction_reg_q <= `DIR_RESET;
		end else if (req.wr_dir) begin
			pin_direction_reg_q <= req.wdata; // see RQ1
		end
	end

	// ==========================================================
	// Output latch, written through either the port or the latch address.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			output_latch_reg_q <= `LAT_RESET;
		end else if (req.wr_latch || req.wr_port) begin
			output_latch_reg_q <= req.wdata; // see RQ3, see RQ21
		end
	end

	// ==========================================================
	// Pull-up control bit.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pullup_enable_n_q <= 1'b1; // see RQ6
		end else if (req.wr_ctl_two) begin
			pullup_enable_n_q <= req.wdata[`PULLUP_CTRL_BIT]; // see RQ4
		end
	end

	// ==========================================================
	// Analog selection of the low pins.
	// The configuration byte is a static same-clock level, so it is
	// taken on the first edge after reset release rather than at reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			analog_select_reg_q <= `ANALOG_RESET; // see RQ7
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			analog_select_reg_q <= {`LOW_PIN_COUNT{config_byte_three_high[`ANALOG_CFG_BIT]}}; // see RQ8
		end else if (req.wr_analog) begin
			analog_select_reg_q <= req.wdata[4:0];
		end
	end

	// ==========================================================
	// Pin ownership. Later assignments win, so the peripheral
	// overrides stand above the latch and direction bit.
	always_comb begin
		eff_oe = ~pin_direction_reg_q; // see RQ2
		eff_out = output_latch_reg_q; // see RQ19
		if (alt.serial_en) begin
			eff_oe[`SERIAL_DATA_PIN] = alt.serial_oe; // see RQ18
			eff_out[`SERIAL_DATA_PIN] = alt.serial_out;
		end
		if (alt.usb_ext_en) begin
			eff_oe[`USB_MINUS_PIN] = 1'b1; // see RQ16, see RQ20
			eff_out[`USB_MINUS_PIN] = alt.usb_xcvr_out_minus;
			eff_oe[`USB_PLUS_PIN] = 1'b1;
			eff_out[`USB_PLUS_PIN] = alt.usb_xcvr_out_plus;
		end
		if (alt.parallel_cs_en) begin
			eff_oe[`PARALLEL_CS_PIN] = 1'b1; // see RQ17, see RQ20
			eff_out[`PARALLEL_CS_PIN] = alt.parallel_port_chip_select;
		end
	end

	// ==========================================================
	// Pin drivers and pull-ups.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_oe_q <= 8'h00;
			pin_out_q <= 8'h00;
			pullup_en_q <= 8'h00;
		end else begin
			pin_oe_q <= eff_oe;
			pin_out_q <= eff_out;
			pullup_en_q <= {`PORT_WIDTH{~pullup_enable_n_q}} & ~eff_oe; // see RQ4, see RQ5
		end
	end

	// ==========================================================
	// Digital input path; analog pins read zero.
	assign level = pin_sync_q & ~{3'b000, analog_select_reg_q}; // see RQ19, see RQ7

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_level_reg_q <= 8'h00;
		end else if (req.rd_port) begin
			pin_level_reg_q <= level; // see RQ21
		end
	end

	// ==========================================================
	// Change detection on the upper pins.
	// Every port read resamples the snapshot, so polling can hide a change.
	assign touch_port = req.rd_port || (req.wr_port && !req.wr_is_move); // see RQ12
	assign mismatch = |((level[`CHANGE_PIN_HI:`CHANGE_PIN_LO] ^ snap_q)
		& ~eff_oe[`CHANGE_PIN_HI:`CHANGE_PIN_LO]); // see RQ9, see RQ11

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			snap_q <= `SNAP_RESET;
		end else if (touch_port) begin
			snap_q <= level[`CHANGE_PIN_HI:`CHANGE_PIN_LO]; // see RQ10
		end
	end

	// A set in the clearing cycle wins, so no change is lost.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_flag_q <= 1'b0;
		end else begin
			pin_change_flag_q <= mismatch || (pin_change_flag_q && !req.clr_flag); // see RQ13
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_req_q <= 1'b0;
		end else begin
			wake_req_q <= mismatch; // see RQ14
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_port_read;
		req.rd_port;
	endsequence

	sequence s_move_write;
		req.wr_port && req.wr_is_move && !req.rd_port;
	endsequence

	sequence s_pullup_on_req;
		req.wr_ctl_two && !req.wdata[`PULLUP_CTRL_BIT];
	endsequence

	sequence s_usb_owned;
		alt.usb_ext_en [*2];
	endsequence

	AST_DIR_DRIVE: assert property (1'b1 |=> pin_oe_q[7:5] == ~$past(pin_direction_reg_q[7:5])) // see RQ2
		else $error("Upper pin enable does not follow direction bits.");

	AST_DRIVE_VALUE: assert property (1'b1 |=> pin_out_q[7:5] == $past(output_latch_reg_q[7:5])) // see RQ2
		else $error("Upper pin output does not follow the latch.");

	AST_LATCH_WRITE: assert property (req.wr_latch |=> output_latch_reg_q == $past(req.wdata)) // see RQ3
		else $error("Latch write not stored.");

	AST_PULLUP_ON: assert property (s_pullup_on_req ##1 !req.wr_ctl_two
		|-> !pullup_enable_n_q ##1 (pullup_en_q == ~$past(eff_oe))) // see RQ4
		else $error("Pull-ups not enabled after control bit cleared.");

	AST_PULLUP_OUT: assert property ((pin_oe_q & pullup_en_q) == 8'h00) // see RQ5
		else $error("Pull-up active on a driven pin.");

	AST_STRAP: assert property ($rose(strap_done_q)
		|-> analog_select_reg_q == {5{$past(config_byte_three_high[1])}}) // see RQ8
		else $error("Low pin default not taken from configuration.");

	AST_ANALOG_READ: assert property (s_port_read
		|=> (pin_level_reg_q[4:0] & $past(analog_select_reg_q)) == 5'h00) // see RQ7
		else $error("Analog pin read as nonzero.");

	AST_SNAPSHOT: assert property (s_port_read |=> snap_q == $past(level[7:4])) // see RQ10
		else $error("Port read did not update the snapshot.");

	AST_MOVE_KEEPS: assert property (s_move_write |=> $stable(snap_q)) // see RQ12
		else $error("Move write ended the mismatch.");

	AST_FLAG_SET: assert property (mismatch |=> pin_change_flag_q && wake_req_q) // see RQ11
		else $error("Mismatch did not set flag and wake.");

	AST_FLAG_HOLD: assert property (pin_change_flag_q && !req.clr_flag && !mismatch
		|=> pin_change_flag_q) // see RQ13
		else $error("Flag dropped without a clear.");

	AST_USB_OWN: assert property (s_usb_owned |-> pin_oe_q[3:2] == 2'b11) // see RQ16
		else $error("USB pins not driven in transceiver mode.");

endmodule
`default_nettype wire

// ==== shared/gpio_port_defs.svh ====
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// ==========================================================
// Port geometry.
`define PORT_WIDTH 8
`define LOW_PIN_COUNT 5
`define CHANGE_PIN_LO 4
`define CHANGE_PIN_HI 7
`define SERIAL_DATA_PIN 0
`define USB_MINUS_PIN 2
`define USB_PLUS_PIN 3
`define PARALLEL_CS_PIN 4

// ==========================================================
// Bit positions inside control bytes.
`define PULLUP_CTRL_BIT 7
`define CHANGE_FLAG_BIT 0
`define ANALOG_CFG_BIT 1

// ==========================================================
// Reset values.
`define DIR_RESET 8'hFF
`define LAT_RESET 8'h00
`define ANALOG_RESET 5'h1F
`define SNAP_RESET 4'h0

`endif

// ==== shared/gpio_port_pkg.sv ====
package gpio_port_pkg;

	// ==========================================================
	// Software access strobes, one cycle each, with write data.
	typedef struct packed {
		logic rd_port;
		logic wr_port;
		logic wr_is_move;
		logic wr_latch;
		logic wr_dir;
		logic wr_ctl_two;
		logic wr_analog;
		logic clr_flag;
		logic [7:0] wdata;
	} reg_req_t;

	// ==========================================================
	// Alternate peripheral functions that may own a pin.
	typedef struct packed {
		logic serial_en;
		logic serial_oe;
		logic serial_out;
		logic usb_ext_en;
		logic usb_xcvr_out_minus;
		logic usb_xcvr_out_plus;
		logic parallel_cs_en;
		logic parallel_port_chip_select;
	} alt_func_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for pin levels.
module pin_sync #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_q
);

	logic [W-1:0] meta_q;

	// Only the second stage may be read by logic.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ==== verif/pin_world.sv ====
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Board side of the port: one external driver and one weak pull-up per pin.
module pin_world (
	input wire logic mclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_en,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_drv,
	output logic [7:0] pin_level
);
	logic [7:0] last_q;

	// A floating pin flips every cycle, so a stale level never passes for a real one.
	always_ff @(posedge mclk) begin
		last_q <= pin_level;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_level[i] = pin_out[i];
			end else if (ext_drv[i]) begin
				pin_level[i] = ext_val[i];
			end else if (pullup_en[i]) begin
				pin_level[i] = 1'b1;
			end else begin
				pin_level[i] = ~last_q[i];
			end
		end
	end
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module testbench
	import gpio_port_pkg::*;
;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] cfg = 8'h02;
	reg_req_t req = '0;
	alt_func_t alt = '0;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] ext_drv = 8'hff;
	logic [7:0] pin_in, pin_out, pin_oe, pu_en, lvl, lat, dir;
	logic [4:0] ana;
	logic pu_n, flag, wake;
	int n_errors = 0;
	int cmp_count = 0;

	gpio_port_b uut (.mclk(mclk), .rst_n(rst_n), .pin_in(pin_in),
		.config_byte_three_high(cfg), .req(req), .alt(alt), .pin_out_q(pin_out),
		.pin_oe_q(pin_oe), .pullup_en_q(pu_en), .pin_level_reg_q(lvl),
		.output_latch_reg_q(lat), .pin_direction_reg_q(dir), .analog_select_reg_q(ana),
		.pullup_enable_n_q(pu_n), .pin_change_flag_q(flag), .wake_req_q(wake));
	pin_world board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pu_en),
		.ext_val(ext_val), .ext_drv(ext_drv), .pin_level(pin_in));

	initial begin
		forever #50 mclk = ~mclk;
	end

	// ==========================================================
	// Shared drivers.
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// One strobe cycle, then one more so the pin outputs have settled.
	task automatic op(input reg_req_t r);
		@(negedge mclk);
		req = r;
		@(negedge mclk);
		req = '0;
		@(negedge mclk);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wait_flag;
		for (int k = 0; k < 8 && flag !== 1'b1; k++) begin
			@(negedge mclk);
		end
		if (flag !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: flag never rose", $time);
			test_done();
		end
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_reset;
		`CHK(dir, 8'hff)
		`CHK(lat, 8'h00)
		`CHK(ana, 5'h1f)
		`CHK(({pu_n, pu_en}), 9'h100)
		rst_n = 1'b1;
		idle(2);
		`CHK(ana, 5'h1f)
		$display("reset test done");
	endtask

	task automatic t_drive;
		op('{wr_ctl_two: 1'b1, default: '0});
		`CHK(pu_en, 8'hff)
		op('{wr_latch: 1'b1, wdata: 8'ha5, default: '0});
		op('{wr_dir: 1'b1, wdata: 8'hf0, default: '0});
		`CHK(lat, 8'ha5)
		`CHK(pin_oe, 8'h0f)
		`CHK(pin_out & pin_oe, 8'h05)
		`CHK(pu_en, 8'hf0)
		op('{wr_dir: 1'b1, wdata: 8'hff, default: '0});
		$display("drive test done");
	endtask

	task automatic t_analog;
		ext_val = 8'h0f;
		idle(3);
		op('{rd_port: 1'b1, default: '0});
		`CHK(lvl, 8'h00)
		op('{wr_analog: 1'b1, default: '0});
		op('{rd_port: 1'b1, default: '0});
		`CHK(lvl, 8'h0f)
		$display("analog test done");
	endtask

	// Reads are issued only where the snapshot is meant to move.
	task automatic t_change;
		op('{clr_flag: 1'b1, default: '0});
		ext_val = 8'h0d;
		idle(6);
		`CHK(flag, 1'b0)
		ext_val = 8'h2d;
		wait_flag();
		idle(1);
		`CHK(({flag, wake}), 2'b11)
		op('{wr_port: 1'b1, wr_is_move: 1'b1, default: '0});
		op('{clr_flag: 1'b1, default: '0});
		`CHK(({flag, wake}), 2'b11)
		op('{rd_port: 1'b1, default: '0});
		`CHK(lvl, 8'h2d)
		op('{clr_flag: 1'b1, default: '0});
		`CHK(({flag, wake}), 2'b00)
		ext_val = 8'h0d;
		wait_flag();
		op('{wr_port: 1'b1, wdata: 8'h11, default: '0});
		op('{clr_flag: 1'b1, default: '0});
		`CHK(({flag, wake}), 2'b00)
		`CHK(lat, 8'h11)
		op('{wr_latch: 1'b1, wdata: 8'h40, default: '0});
		op('{wr_dir: 1'b1, wdata: 8'hbf, default: '0});
		idle(4);
		`CHK(flag, 1'b0)
		$display("change test done");
	endtask

	task automatic t_alt;
		alt = 8'hfb;
		idle(3);
		`CHK(pin_oe, 8'h5d)
		`CHK(pin_out & 8'h1d, 8'h15)
		`CHK(pin_out[4], 1'b1)
		`CHK(pin_out[0], 1'b1)
		`CHK(pu_en, 8'ha2)
		$display("alternate test done");
	endtask

	task automatic t_strap;
		cfg = 8'h00;
		rst_n = 1'b0;
		idle(1);
		rst_n = 1'b1;
		idle(2);
		`CHK(ana, 5'h00)
		$display("strap test done");
	endtask

	initial begin
		repeat (2) @(negedge mclk);
		t_reset();
		t_drive();
		t_analog();
		t_change();
		t_alt();
		t_strap();
		test_done();
	end
endmodule

`default_nettype wire
